// ===== logic/rss_consts.svh
// Register map, field positions and reset values of the rotate, subtract and skip datapath.
// Assumes a 25 MHz hclk and one AHB-Lite master in front of the register slave.
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define RSS_OFF_CTRL 8'h00
`define RSS_OFF_ACC 8'h04
`define RSS_OFF_FLAGS 8'h08
`define RSS_OFF_STATUS 8'h0c
`define RSS_OFF_SKIPS 8'h10

// ==========================================================================
// Field positions
`define RSS_CTRL_EN_BIT 0
`define RSS_FLAG_C_BIT 0
`define RSS_FLAG_HC_BIT 1
`define RSS_FLAG_Z_BIT 2
`define RSS_FLAG_WRAP_BIT 3
`define RSS_STAT_DUMMY_BIT 0
`define RSS_STAT_READY_BIT 1

// ==========================================================================
// Reset values
`define RSS_CTRL_EN_RST 1'b1
`define RSS_ACC_RST 8'h00
`define RSS_FLAGS_RST 4'h0
`define RSS_SKIPS_RST 16'h0000

// ==========================================================================
// Datapath constants
`define RSS_ALL_ONES 8'hff
`define RSS_ONE 8'h01

`endif

// ===== logic/rss_pkg.sv
// Types shared by the datapath: operation codes, command carrier, flags, state.
// Assumes the instruction sequencer decodes opcodes into rss_op_t.
package rss_pkg;

  // ==========================================================================
  // Operations
  typedef enum logic [4:0] {
    op_idle = 5'h00,
    op_rotate_left_thru_carry = 5'h01,
    op_rotate_left_carry_to_acc = 5'h02,
    op_rotate_right = 5'h03,
    op_rotate_right_to_accum = 5'h04,
    op_rotate_right_thru_carry = 5'h05,
    op_rotate_right_carry_to_acc = 5'h06,
    op_minus_with_borrow = 5'h07,
    op_minus_with_borrow_to_mem = 5'h08,
    op_minus_plain_to_acc = 5'h09,
    op_minus_plain_to_mem = 5'h0a,
    op_minus_immediate = 5'h0b,
    op_decrement_skip_zero = 5'h0c,
    op_decrement_to_acc_skip_zero = 5'h0d,
    op_increment_skip_zero = 5'h0e,
    op_increment_to_acc_skip_zero = 5'h0f,
    op_bit_nonzero_skip = 5'h10,
    op_set_whole_byte = 5'h11,
    op_set_one_bit = 5'h12,
    op_nibble_swap = 5'h13
  } rss_op_t;

  typedef struct packed {
    logic valid;
    rss_op_t op;
    logic [2:0] bit_sel;
    logic [7:0] imm;
  } rss_cmd_t;

  typedef struct packed {
    logic signed_wrap_flag;
    logic zero;
    logic half_carry_flag;
    logic carry;
  } rss_flags_t;

  typedef struct packed {
    logic [7:0] res;
    rss_flags_t fl;
  } rss_alu_t;

  typedef enum logic [0:0] {
    st_exec = 1'b0,
    st_dummy = 1'b1
  } rss_state_t;

endpackage

// ===== logic/rss_datapath.sv
// Execution datapath for rotates, subtracts, skips, set and nibble swap, with an
// AHB-Lite register slave. Assumes the sequencer presents the addressed byte on
// mem_rdata in the cycle the command is offered, and holds the command while not ready.
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ns
`include "rss_consts.svh"

module rss_datapath import rss_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire rss_cmd_t cmd,
  input wire logic [7:0] mem_rdata,
  output logic cmd_ready,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  output logic [7:0] acc,
  output rss_flags_t flags,
  output logic skip,
  output logic dummy
);

  // ==========================================================================
  // Arithmetic helpers
  function automatic rss_alu_t rss_minus(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
    logic [8:0] s;
    logic [4:0] h;
    rss_alu_t r;
    s = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    r.res = s[7:0];
    r.fl.carry = s[8];
    r.fl.half_carry_flag = h[4];
    r.fl.zero = (s[7:0] == 8'h00);
    // Operands of opposite sign and result sign differing from minuend
    r.fl.signed_wrap_flag = (a[7] != b[7]) && (s[7] != a[7]);
    return r;
  endfunction

  function automatic logic [31:0] rss_word(input logic [7:0] v);
    return {24'h000000, v};
  endfunction

  // ==========================================================================
  // State
  rss_state_t st_r, st_nxt;
  logic ready_r, ready_nxt;
  logic ctrl_en_r;
  logic [7:0] acc_r, acc_nxt;
  rss_flags_t flags_r, flags_nxt;
  logic mem_we_r, mem_we_nxt;
  logic [7:0] mem_wdata_r, mem_wdata_nxt;
  logic skip_r, skip_nxt;
  logic [15:0] skips_r;
  logic go;
  rss_alu_t sub_res;
  logic [7:0] dec_v, inc_v, bit_mask;

  // AHB data phase
  logic dph_wr_r;
  logic [7:0] dph_addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic addr_take;
  logic sw_acc_wr, sw_fl_wr, sw_ctrl_wr;

  assign go = cmd.valid && ready_r;
  assign dec_v = mem_rdata - `RSS_ONE;
  assign inc_v = mem_rdata + `RSS_ONE;
  assign bit_mask = `RSS_ONE << cmd.bit_sel;

  // ==========================================================================
  // Execution decode
  always_comb begin
    st_nxt = st_exec;
    acc_nxt = acc_r;
    flags_nxt = flags_r;
    mem_we_nxt = 1'b0;
    mem_wdata_nxt = mem_wdata_r;
    skip_nxt = 1'b0;
    sub_res = rss_minus(acc_r, mem_rdata, flags_r.carry);
    if (go) begin
      unique case (cmd.op)
        op_idle: begin
        end
        op_rotate_left_thru_carry: begin
          mem_we_nxt = 1'b1;
          mem_wdata_nxt = {mem_rdata[6:0], flags_r.carry};
          flags_nxt.carry = mem_rdata[7];
        end
        op_rotate_left_carry_to_acc: begin
          acc_nxt = {mem_rdata[6:0], flags_r.carry};
          flags_nxt.carry = mem_rdata[7];
        end
        op_rotate_right: begin
          mem_we_nxt = 1'b1;
          mem_wdata_nxt = {mem_rdata[0], mem_rdata[7:1]};
        end
        op_rotate_right_to_accum: begin
          acc_nxt = {mem_rdata[0], mem_rdata[7:1]};
        end
        op_rotate_right_thru_carry: begin
          mem_we_nxt = 1'b1;
          mem_wdata_nxt = {flags_r.carry, mem_rdata[7:1]};
          flags_nxt.carry = mem_rdata[0];
        end
        op_rotate_right_carry_to_acc: begin
          acc_nxt = {flags_r.carry, mem_rdata[7:1]};
          flags_nxt.carry = mem_rdata[0];
        end
        op_minus_with_borrow: begin
          acc_nxt = sub_res.res;
          flags_nxt = sub_res.fl;
        end
        op_minus_with_borrow_to_mem: begin
          mem_we_nxt = 1'b1;
          mem_wdata_nxt = sub_res.res;
          flags_nxt = sub_res.fl;
        end
        op_minus_plain_to_acc: begin
          sub_res = rss_minus(acc_r, mem_rdata, 1'b1);
          acc_nxt = sub_res.res;
          flags_nxt = sub_res.fl;
        end
        op_minus_plain_to_mem: begin
          sub_res = rss_minus(acc_r, mem_rdata, 1'b1);
          mem_we_nxt = 1'b1;
          mem_wdata_nxt = sub_res.res;
          flags_nxt = sub_res.fl;
        end
        op_minus_immediate: begin
          sub_res = rss_minus(acc_r, cmd.imm, 1'b1);
          acc_nxt = sub_res.res;
          flags_nxt = sub_res.fl;
        end
        op_decrement_skip_zero: begin
          mem_we_nxt = 1'b1;
          mem_wdata_nxt = dec_v;
          skip_nxt = (dec_v == 8'h00);
        end
        op_decrement_to_acc_skip_zero: begin
          acc_nxt = dec_v;
          skip_nxt = (dec_v == 8'h00);
        end
        op_increment_skip_zero: begin
          mem_we_nxt = 1'b1;
          mem_wdata_nxt = inc_v;
          skip_nxt = (inc_v == 8'h00);
        end
        op_increment_to_acc_skip_zero: begin
          acc_nxt = inc_v;
          skip_nxt = (inc_v == 8'h00);
        end
        op_bit_nonzero_skip: begin
          skip_nxt = |(mem_rdata & bit_mask);
        end
        op_set_whole_byte: begin
          mem_we_nxt = 1'b1;
          mem_wdata_nxt = `RSS_ALL_ONES;
        end
        op_set_one_bit: begin
          mem_we_nxt = 1'b1;
          mem_wdata_nxt = mem_rdata | bit_mask;
        end
        op_nibble_swap: begin
          mem_we_nxt = 1'b1;
          mem_wdata_nxt = {mem_rdata[3:0], mem_rdata[7:4]};
        end
        default: begin
        end
      endcase
    end
    // Prefetched word is dropped by holding ready low for one slot
    if (skip_nxt) begin
      st_nxt = st_dummy;
    end
    ready_nxt = (st_nxt == st_exec) && ctrl_en_r;
  end

  // ==========================================================================
  // Sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= st_exec;
      ready_r <= 1'b0;
      skip_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_wdata_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      ready_r <= ready_nxt;
      skip_r <= skip_nxt;
      mem_we_r <= mem_we_nxt;
      mem_wdata_r <= mem_wdata_nxt;
    end
  end

  // Datapath result wins over a software write in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= `RSS_ACC_RST;
    end else if (acc_nxt != acc_r || go) begin
      acc_r <= acc_nxt;
    end else if (sw_acc_wr) begin
      acc_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= `RSS_FLAGS_RST;
    end else if (go) begin
      flags_r <= flags_nxt;
    end else if (sw_fl_wr) begin
      flags_r <= hwdata[3:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      skips_r <= `RSS_SKIPS_RST;
    end else if (skip_nxt) begin
      skips_r <= skips_r + 16'h0001;
    end
  end

  // ==========================================================================
  // AHB-Lite register slave, zero wait states
  assign addr_take = hsel && hready && htrans[1];
  assign sw_acc_wr = dph_wr_r && (dph_addr_r == `RSS_OFF_ACC);
  assign sw_fl_wr = dph_wr_r && (dph_addr_r == `RSS_OFF_FLAGS);
  assign sw_ctrl_wr = dph_wr_r && (dph_addr_r == `RSS_OFF_CTRL);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_r <= 1'b0;
      dph_addr_r <= 8'h00;
    end else begin
      dph_wr_r <= addr_take && hwrite;
      dph_addr_r <= addr_take ? haddr[7:0] : dph_addr_r;
    end
  end

  // Read data sampled in the address phase, so it is one cycle old
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (addr_take && !hwrite) begin
      unique case (haddr[7:0])
        `RSS_OFF_CTRL: hrdata_r <= rss_word({7'h00, ctrl_en_r});
        `RSS_OFF_ACC: hrdata_r <= rss_word(acc_r);
        `RSS_OFF_FLAGS: hrdata_r <= rss_word({4'h0, flags_r});
        `RSS_OFF_STATUS: hrdata_r <= rss_word({6'h00, ready_r, st_r == st_dummy});
        `RSS_OFF_SKIPS: hrdata_r <= {16'h0000, skips_r};
        default: hrdata_r <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en_r <= `RSS_CTRL_EN_RST;
    end else if (sw_ctrl_wr) begin
      ctrl_en_r <= hwdata[`RSS_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hrdata = hrdata_r;
  assign hresp = hresp_r;
  assign cmd_ready = ready_r;
  assign mem_we = mem_we_r;
  assign mem_wdata = mem_wdata_r;
  assign acc = acc_r;
  assign flags = flags_r;
  assign skip = skip_r;
  assign dummy = (st_r == st_dummy) ? 1'b1 : 1'b0;

  // ==========================================================================
  // Checks; helper registers hold the previous cycle's command, operands and flags
  logic p_go_r;
  rss_op_t p_op_r;
  logic [7:0] p_m_r, p_acc_r, p_imm_r;
  rss_flags_t p_fl_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p_go_r <= 1'b0;
      p_op_r <= op_idle;
      p_m_r <= 8'h00;
      p_acc_r <= 8'h00;
      p_imm_r <= 8'h00;
      p_fl_r <= 4'h0;
    end else begin
      p_go_r <= go;
      p_op_r <= cmd.op;
      p_m_r <= mem_rdata;
      p_acc_r <= acc_r;
      p_imm_r <= cmd.imm;
      p_fl_r <= flags_r;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence took_op(rss_op_t o);
    p_go_r && p_op_r == o;
  endsequence

  sequence skip_taken;
    go && skip_nxt;
  endsequence

  rotl_carry_mem_a: assert property (took_op(op_rotate_left_thru_carry) |->
    mem_we_r && mem_wdata_r == {p_m_r[6:0], p_fl_r.carry} && flags_r.carry == p_m_r[7])
    else $error("left rotate through carry wrong");
  rotl_carry_acc_a: assert property (took_op(op_rotate_left_carry_to_acc) |->
    !mem_we_r && acc_r == {p_m_r[6:0], p_fl_r.carry} && flags_r.carry == p_m_r[7])
    else $error("left rotate to accumulator wrong");
  rotr_mem_a: assert property (took_op(op_rotate_right) |->
    mem_we_r && mem_wdata_r == {p_m_r[0], p_m_r[7:1]} && flags_r == p_fl_r)
    else $error("right rotate wrong");
  rotr_acc_a: assert property (took_op(op_rotate_right_to_accum) |->
    !mem_we_r && acc_r == {p_m_r[0], p_m_r[7:1]} && flags_r == p_fl_r)
    else $error("right rotate to accumulator wrong");
  rotr_carry_mem_a: assert property (took_op(op_rotate_right_thru_carry) |->
    mem_we_r && mem_wdata_r == {p_fl_r.carry, p_m_r[7:1]} && flags_r.carry == p_m_r[0])
    else $error("right rotate through carry wrong");
  rotr_carry_acc_a: assert property (took_op(op_rotate_right_carry_to_acc) |->
    !mem_we_r && acc_r == {p_fl_r.carry, p_m_r[7:1]} && flags_r == {p_fl_r[3:1], p_m_r[0]})
    else $error("right rotate carry to accumulator wrong");
  borrow_sub_a: assert property (took_op(op_minus_with_borrow) |->
    acc_r == p_acc_r + ~p_m_r + {7'h00, p_fl_r.carry} && flags_r.zero == (acc_r == 8'h00))
    else $error("borrow subtract wrong");
  sub_mem_a: assert property (took_op(op_minus_plain_to_mem) |->
    mem_we_r && mem_wdata_r == p_acc_r - p_m_r && flags_r.carry == (p_acc_r >= p_m_r))
    else $error("plain subtract to memory wrong");
  sub_imm_a: assert property (took_op(op_minus_immediate) |->
    acc_r == p_acc_r - p_imm_r && flags_r.carry == (p_acc_r >= p_imm_r))
    else $error("immediate subtract wrong");
  dec_skip_a: assert property (took_op(op_decrement_skip_zero) |->
    mem_we_r && mem_wdata_r == p_m_r - 8'h01 && skip_r == (p_m_r == 8'h01) && flags_r == p_fl_r)
    else $error("decrement skip wrong");
  inc_acc_a: assert property (took_op(op_increment_to_acc_skip_zero) |->
    !mem_we_r && acc_r == p_m_r + 8'h01 && skip_r == (p_m_r == 8'hff))
    else $error("increment to accumulator skip wrong");
  skip_dummy_a: assert property (skip_taken |=> skip_r && dummy && !cmd_ready ##1 !dummy)
    else $error("skip dummy cycle wrong");
  set_byte_a: assert property (took_op(op_set_whole_byte) |->
    mem_we_r && mem_wdata_r == 8'hff && flags_r == p_fl_r)
    else $error("byte set wrong");
  swap_mem_a: assert property (took_op(op_nibble_swap) |->
    mem_we_r && mem_wdata_r == {p_m_r[3:0], p_m_r[7:4]})
    else $error("nibble swap wrong");
  dummy_nop_a: assert property (dummy && !sw_acc_wr && !sw_fl_wr |=>
    !mem_we_r && !skip_r && $stable(acc_r) && $stable(flags_r))
    else $error("dummy cycle changed state");

endmodule

// ===== verif/rss_mem_model.sv
// Partner model: the core's data memory as the instruction sequencer presents it.
// Assumes the bench plays the sequencer: it names the byte on addr and preloads it.
`timescale 1ns/1ns

module rss_mem_model import rss_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] addr,
  input wire logic load_en,
  input wire logic [7:0] load_data,
  input wire rss_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  // ==========================================================================
  // Storage and write-back address
  logic [7:0] mem_r [16];
  logic [3:0] wr_addr_r;

  // Write-back lands one edge after the take, so the address is kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_addr_r <= 4'h0;
    end else if (cmd.valid && cmd_ready) begin
      wr_addr_r <= addr;
    end
  end

  // Datapath write wins over a preload
  always_ff @(posedge hclk) begin
    if (mem_we) begin
      mem_r[wr_addr_r] <= mem_wdata;
    end else if (load_en) begin
      mem_r[addr] <= load_data;
    end
  end

  assign mem_rdata = mem_r[addr];
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the rotate, subtract and skip datapath.
// Assumes the register slave is alone on the bus, so hready is its own hreadyout.
`timescale 1ns/1ns
`include "rss_consts.svh"

module testbench import rss_pkg::*;;
  typedef struct packed {
    logic [7:0] res;
    logic wm;
    logic wa;
    rss_flags_t fl;
    logic sk;
  } rss_exp_t;

  // ==========================================================================
  // Signals
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, r, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  rss_cmd_t cmd;
  logic [7:0] mem_rdata, mem_wdata, acc, exp_acc, load_data;
  logic cmd_ready, mem_we, skip, dummy, load_en;
  rss_flags_t flags, exp_fl;
  logic [3:0] addr;
  logic [15:0] n_skip;
  int n_mismatch, checks;
  logic [7:0] roff [6] = '{`RSS_OFF_CTRL, `RSS_OFF_ACC, `RSS_OFF_FLAGS, `RSS_OFF_STATUS,
                           `RSS_OFF_SKIPS, 8'h14};
  logic [31:0] rrst [6] = '{32'h1, 32'h0, 32'h0, 32'h2, 32'h0, 32'h0};

  assign hready = hreadyout;

  rss_datapath dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cmd(cmd),
    .mem_rdata(mem_rdata), .cmd_ready(cmd_ready), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .acc(acc), .flags(flags), .skip(skip), .dummy(dummy));

  rss_mem_model pm (.hclk(hclk), .hresetn(hresetn), .addr(addr), .load_en(load_en),
    .load_data(load_data), .cmd(cmd), .cmd_ready(cmd_ready), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic rss_exp_t calc(input rss_op_t op, input logic [7:0] m,
      input logic [7:0] a, input rss_flags_t f, input logic [2:0] bs, input logic [7:0] imm);
    rss_exp_t e;
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] b;
    logic cin;
    e = '{res: 8'h00, wm: 1'b0, wa: 1'b0, fl: f, sk: 1'b0};
    b = (op == op_minus_immediate) ? imm : m;
    cin = (op inside {op_minus_with_borrow, op_minus_with_borrow_to_mem}) ? f.carry : 1'b1;
    s = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    case (op)
      op_rotate_left_thru_carry, op_rotate_left_carry_to_acc: begin
        e.res = {m[6:0], f.carry};
        e.fl.carry = m[7];
      end
      op_rotate_right, op_rotate_right_to_accum: e.res = {m[0], m[7:1]};
      op_rotate_right_thru_carry, op_rotate_right_carry_to_acc: begin
        e.res = {f.carry, m[7:1]};
        e.fl.carry = m[0];
      end
      op_decrement_skip_zero, op_decrement_to_acc_skip_zero: e.res = m - 8'h01;
      op_increment_skip_zero, op_increment_to_acc_skip_zero: e.res = m + 8'h01;
      op_bit_nonzero_skip: e.sk = m[bs];
      op_set_whole_byte: e.res = 8'hff;
      op_set_one_bit: e.res = m | (8'h01 << bs);
      op_nibble_swap: e.res = {m[3:0], m[7:4]};
      default: begin
        e.res = s[7:0];
        e.fl = '{signed_wrap_flag: (a[7] != b[7]) && (s[7] != a[7]),
                 zero: s[7:0] == 8'h00, half_carry_flag: h[4], carry: s[8]};
      end
    endcase
    e.wa = op inside {op_rotate_left_carry_to_acc, op_rotate_right_to_accum,
      op_rotate_right_carry_to_acc, op_minus_with_borrow, op_minus_plain_to_acc,
      op_minus_immediate, op_decrement_to_acc_skip_zero, op_increment_to_acc_skip_zero};
    e.wm = !e.wa && op != op_bit_nonzero_skip;
    if (op inside {op_decrement_skip_zero, op_decrement_to_acc_skip_zero,
        op_increment_skip_zero, op_increment_to_acc_skip_zero}) begin
      e.sk = e.res == 8'h00;
    end
    return e;
  endfunction

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Bounded wait on a signal sampled at each rising edge
  task automatic wait_hi(input string what);
    int n;
    n = 0;
    @(posedge hclk);
    while ((what == "bus" ? hready : cmd_ready) !== 1'b1) begin
      n++;
      if (n > 50) begin
        chk(1'b0, "wait timed out");
        summarize();
      end
      @(posedge hclk);
    end
  endtask

  // ==========================================================================
  // Bus master: one single word transfer
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_hi("bus");
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wr ? wd : 32'h0;
    wait_hi("bus");
    rd = hrdata;
    chk(hresp === 1'b0, "bus response");
  endtask

  // Sequencer side: preload the byte, offer one command, check its results
  task automatic run(input rss_op_t op, input logic [3:0] ad, input logic [7:0] m,
      input logic [2:0] bs, input logic [7:0] imm);
    rss_exp_t e;
    addr <= ad;
    load_en <= 1'b1;
    load_data <= m;
    @(posedge hclk);
    load_en <= 1'b0;
    cmd <= '{valid: 1'b1, op: op, bit_sel: bs, imm: imm};
    e = calc(op, m, exp_acc, exp_fl, bs, imm);
    wait_hi("cmd");
    cmd <= '0;
    #1;
    if (e.wa) exp_acc = e.res;
    exp_fl = e.fl;
    chk(mem_we === e.wm, "memory write strobe");
    chk(!e.wm || mem_wdata === e.res, "memory data");
    chk(acc === exp_acc, "accumulator");
    chk(flags === exp_fl, "flags");
    chk(skip === e.sk && dummy === e.sk, "skip request");
    chk(cmd_ready === !e.sk, "ready after take");
    if (e.sk) begin
      n_skip++;
      @(posedge hclk);
      #1;
      chk(dummy === 1'b0 && skip === 1'b0 && mem_we === 1'b0, "dummy length");
      chk(acc === exp_acc && flags === exp_fl && cmd_ready === 1'b1, "dummy state");
    end
    @(posedge hclk);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cmd = '0;
    addr = 4'h0;
    load_en = 1'b0;
    load_data = 8'h00;
    n_mismatch = 0;
    checks = 0;
    seed = 32'h00017908;
    n_skip = 16'h0000;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b1, 8'h14, 32'hffffffff);
    for (int i = 0; i < 6; i++) begin
      ahb(1'b0, roff[i], 32'h0);
      chk(rd === rrst[i], "register reset value");
    end
    r = rnd();
    ahb(1'b1, `RSS_OFF_ACC, {24'h0, r[7:0]});
    ahb(1'b1, `RSS_OFF_FLAGS, {28'h0, r[11:8]});
    exp_acc = r[7:0];
    exp_fl = rss_flags_t'(r[11:8]);
    // Corner cases: skip boundaries, bit test set and clear, immediate subtract
    run(op_decrement_skip_zero, 4'h1, 8'h01, 3'h0, 8'h00);
    run(op_decrement_to_acc_skip_zero, 4'h2, 8'h01, 3'h0, 8'h00);
    run(op_decrement_skip_zero, 4'h3, 8'h00, 3'h0, 8'h00);
    run(op_increment_skip_zero, 4'h4, 8'hff, 3'h0, 8'h00);
    run(op_increment_to_acc_skip_zero, 4'h5, 8'hff, 3'h0, 8'h00);
    run(op_bit_nonzero_skip, 4'h6, 8'h80, 3'h7, 8'h00);
    run(op_bit_nonzero_skip, 4'h7, 8'h7f, 3'h7, 8'h00);
    run(op_minus_immediate, 4'h8, 8'h00, 3'h0, 8'h80);
    for (int o = 1; o < 20; o++) begin
      r = rnd();
      run(rss_op_t'(o[4:0]), r[3:0], r[11:4], r[14:12], r[22:15]);
    end
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      if (r[31:30] == 2'h0) begin
        ahb(1'b1, `RSS_OFF_FLAGS, {28'h0, r[27:24]});
        exp_fl = rss_flags_t'(r[27:24]);
      end
      run(rss_op_t'(5'h01 + 5'(r[23:16] % 8'd19)), r[3:0], r[11:4], r[14:12], r[29:22]);
    end
    ahb(1'b0, `RSS_OFF_ACC, 32'h0);
    chk(rd === {24'h0, exp_acc}, "accumulator readback");
    ahb(1'b0, `RSS_OFF_FLAGS, 32'h0);
    chk(rd === {28'h0, exp_fl}, "flags readback");
    ahb(1'b0, `RSS_OFF_SKIPS, 32'h0);
    chk(rd === {16'h0, n_skip}, "skip count");
    // Disabled core refuses commands
    ahb(1'b1, `RSS_OFF_CTRL, 32'h0);
    @(posedge hclk);
    cmd <= '{valid: 1'b1, op: op_set_whole_byte, bit_sel: 3'h0, imm: 8'h00};
    repeat (4) begin
      @(posedge hclk);
      chk(cmd_ready === 1'b0 && mem_we === 1'b0, "refused while disabled");
    end
    cmd <= '0;
    ahb(1'b0, `RSS_OFF_STATUS, 32'h0);
    chk(rd === 32'h0, "status while disabled");
    ahb(1'b1, `RSS_OFF_CTRL, 32'h1);
    run(op_set_whole_byte, 4'h9, 8'h12, 3'h0, 8'h00);
    summarize();
  end
endmodule
